// ==== rtl/smr_defs.svh ====
// Offsets, field positions, reset values and widths of the status and mode register bank
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH

// Register addresses on the internal register port
`define SMR_ADDR_STATUS   3'h0
`define SMR_ADDR_IRQ      3'h1
`define SMR_ADDR_MODE     3'h2

// Reset values
`define SMR_STATUS_RST    8'h00
`define SMR_MODE_RST      8'h00
`define SMR_IRQ_RST       8'h00

// Bits that exist; the others read as zero
`define SMR_STATUS_USED   8'hDF
`define SMR_IRQ_USED      8'hDD

// Field positions of the latched interrupt register; all but wake shared with status
`define SMR_B_THERMAL_SHUTDOWN_FLAG      7
`define SMR_B_WAKE        6
`define SMR_B_FAULT       4
`define SMR_B_SUPWARN     3
`define SMR_B_UVLO        2
`define SMR_B_OVERTEMP_WARNING       0

// Mode field positions
`define SMR_M_RST         7

// Synchroniser width and input positions
`define SMR_SYNC_W        10
`define SMR_I_THERMAL_SHUTDOWN_FLAG      0
`define SMR_I_AUX         1
`define SMR_I_FAULT       2
`define SMR_I_SUPWARN     3
`define SMR_I_UVLO        4
`define SMR_I_LINE        5
`define SMR_I_TEMPHI      6
`define SMR_I_TEMPLO      7
`define SMR_I_WAKE        8
`define SMR_I_IND1        9

`endif

// ==== rtl/smr_pkg.sv ====
// Types of the status and mode register bank
package smr_pkg;

    // Operating control register, bit 7 down to bit 0
    typedef struct packed {
        logic rst;
        logic wakeupDetectOff;
        logic regulator3v3Off;
        logic serialMuxOn;
        logic supplyWarningIrqOn;
        logic rxFilterBypass;
        logic indicator2Level;
        logic indicator1Force;
    } smr_mode_t;

    // Live condition flags register, bit 7 down to bit 0
    typedef struct packed {
        logic thermalShutdownFlag;
        logic auxInputLevel;
        logic unused5;
        logic lineDriverFaultBit;
        logic supplyLowWarning;
        logic supplyUndervoltage;
        logic lineLevel;
        logic overtempWarning;
    } smr_status_t;

    // State of the register bank top
    typedef struct packed {
        smr_mode_t   mode;
        smr_status_t status;
        smr_status_t statusPrev;
        logic        wakePrev;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        indicator1Out;
    } smr_top_state_t;

    // State of the synchroniser
    typedef struct packed {
        logic [9:0] stage1;
        logic [9:0] stage2;
    } smr_sync_state_t;

    // State of the interrupt latch
    typedef struct packed {
        logic [7:0] flags;
        logic       irqN;
    } smr_irq_state_t;

endpackage

// ==== rtl/smr_irq_if.sv ====
// Connection between the register bank top and its interrupt latch
`timescale 1ns/1ns
`default_nettype none

interface smr_irq_if;
    logic [7:0] events;
    logic       clearAll;
    logic       suppress;
    logic [7:0] flags;
    logic       irqN;

    modport src   (output events, output clearAll, output suppress, input flags, input irqN);
    modport latch (input events, input clearAll, input suppress, output flags, output irqN);
endinterface

`default_nettype wire

// ==== rtl/smr_sync.sv ====
// Two-stage synchroniser for the asynchronous condition inputs
`timescale 1ns/1ns
`default_nettype none
`include "smr_defs.svh"

module smr_sync (
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic [`SMR_SYNC_W-1:0] asyncIn,
    output logic      [`SMR_SYNC_W-1:0] syncOut
);
    smr_pkg::smr_sync_state_t st_d;
    smr_pkg::smr_sync_state_t st_q;

    // Stage 1 is only ever read by stage 2, to keep metastability contained
    always_comb begin
        st_d        = st_q;
        st_d.stage1 = asyncIn;
        st_d.stage2 = st_q.stage1;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign syncOut = st_q.stage2;
endmodule // smr_sync

`default_nettype wire

// ==== rtl/smr_irq.sv ====
// Latched interrupt flags with read-to-clear and the active-low interrupt output
`timescale 1ns/1ns
`default_nettype none
`include "smr_defs.svh"

module smr_irq (
    input  wire logic clock,
    input  wire logic rstn,
    smr_irq_if.latch  irq
);
    smr_pkg::smr_irq_state_t st_d;
    smr_pkg::smr_irq_state_t st_q;
    logic [7:0]              flagNext;

    // Per flag: a new event beats a same-cycle read clear
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : gFlag
            assign flagNext[i] = irq.events[i] | (st_q.flags[i] & ~irq.clearAll);
        end
    endgenerate

    // Register reset wipes all flags and holds them off
    always_comb begin
        st_d = st_q;
        if (irq.suppress) begin
            st_d.flags = `SMR_IRQ_RST; // RL9 RL10
        end else begin
            st_d.flags = flagNext & `SMR_IRQ_USED; // RL19
        end
        st_d.irqN = ~(|st_d.flags); // RL19
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q.flags <= `SMR_IRQ_RST;
            st_q.irqN  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign irq.flags = st_q.flags;
    assign irq.irqN  = st_q.irqN;
endmodule // smr_irq

`default_nettype wire

// ==== rtl/status_mode_registers.sv ====
// Status and mode registers of the sensor-line transceiver configuration bank
//
// Contract
// RL1: Bit 7 follows thermal shutdown state.
// RL2: Bit 6 is inverted auxiliary input level.
// RL3: Bit 4 follows line driver fault.
// RL4: Bit 3 follows supply low warning.
// RL5: Bit 2 follows supply undervoltage.
// RL6: Bit 1 is inverted line pin level.
// RL7: Bit 0 overtemp warning with hysteresis.
// RL8: Status read-only, zero at reset, bit5 zero.
// RL9: Mode reset bit restores defaults, clears status.
// RL10: No interrupts while reset bit is set.
// RL11: Mode bit 6 disables wake-up detection.
// RL12: Mode bit 5 turns regulator off.
// RL13: Mode bit 4 enables serial multiplexing.
// RL14: Mode bit 3 enables supply-warning interrupt.
// RL15: Mode bit 2 bypasses receive deglitch filter.
// RL16: Mode bit 1 sets indicator 2 level.
// RL17: Mode bit 0 forces indicator 1 high.
// RL18: Mode read/write, zero at reset, stable reads.
// RL19: Interrupt output low while flags; read clears.
// RL20: Wake-up sets flag unless detection disabled.
// RL21: Condition inputs pass two-stage synchroniser.
`timescale 1ns/1ns
`default_nettype none
`include "smr_defs.svh"

module status_mode_registers (
    input  wire logic       clock,
    input  wire logic       rstn,
    // Register port from the serial host interface
    input  wire logic [2:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    output logic            regRvalid,
    // Condition inputs from the analog side
    input  wire logic       thermalShutdown,
    input  wire logic       auxDigitalInput,
    input  wire logic       lineDriverFault,
    input  wire logic       supplyLowWarning,
    input  wire logic       supplyUndervoltage,
    input  wire logic       linePinLevel,
    input  wire logic       tempAboveWarn,
    input  wire logic       tempBelowHyst,
    input  wire logic       wakeupDetect,
    input  wire logic       indicator1Input,
    // Controls to the rest of the device
    output logic            wakeupDetectOff,
    output logic            regulator3v3Off,
    output logic            serialMuxOn,
    output logic            rxFilterBypass,
    output logic            indicator2Level,
    output logic            indicator1Out,
    output logic            faultIrqN
);
    smr_pkg::smr_top_state_t st_d;
    smr_pkg::smr_top_state_t st_q;

    logic [`SMR_SYNC_W-1:0] rawIn;
    logic [`SMR_SYNC_W-1:0] syncIn;
    logic [7:0]             riseVec;
    logic [7:0]             eventVec;
    logic                   irqRead;

    smr_irq_if irqBus ();

    // Address match, used for both read and write decode
    function automatic logic addrHit(input logic [2:0] addr, input logic [2:0] target);
        addrHit = (addr == target);
    endfunction

    // Read data selection; unmapped addresses answer zero
    function automatic logic [7:0] readMux(
        input logic [2:0]          addr,
        input smr_pkg::smr_status_t status,
        input smr_pkg::smr_mode_t   mode,
        input logic [7:0]          flags
    );
        readMux = 8'h00;
        if (addrHit(addr, `SMR_ADDR_STATUS)) begin
            readMux = status & `SMR_STATUS_USED; // RL8
        end else if (addrHit(addr, `SMR_ADDR_IRQ)) begin
            readMux = flags;
        end else if (addrHit(addr, `SMR_ADDR_MODE)) begin
            readMux = mode; // RL18
        end
    endfunction

    // Gather asynchronous inputs for the synchroniser; the two inverted levels
    // are flipped ahead of it so a cleared synchroniser reads as a zero status
    always_comb begin
        rawIn                    = '0;
        rawIn[`SMR_I_THERMAL_SHUTDOWN_FLAG]     = thermalShutdown;
        rawIn[`SMR_I_AUX]        = ~auxDigitalInput; // RL2
        rawIn[`SMR_I_FAULT]      = lineDriverFault;
        rawIn[`SMR_I_SUPWARN]    = supplyLowWarning;
        rawIn[`SMR_I_UVLO]       = supplyUndervoltage;
        rawIn[`SMR_I_LINE]       = ~linePinLevel; // RL6
        rawIn[`SMR_I_TEMPHI]     = tempAboveWarn;
        rawIn[`SMR_I_TEMPLO]     = tempBelowHyst;
        rawIn[`SMR_I_WAKE]       = wakeupDetect;
        rawIn[`SMR_I_IND1]       = indicator1Input;
    end

    smr_sync uSync (
        .clock   (clock),
        .rstn    (rstn),
        .asyncIn (rawIn),
        .syncOut (syncIn) // RL21
    );

    // Rising edges of the registered status flags; those of bits 7, 4, 3, 2 and 0 are interrupt sources
    assign riseVec = st_q.status & ~st_q.statusPrev;

    // Interrupt sources; all edges but wake are taken from registered flags so a glitch on
    // the raw pin cannot fire those events without also showing in status; wake uses the synchronised input
    always_comb begin
        eventVec                 = 8'h00;
        eventVec[`SMR_B_THERMAL_SHUTDOWN_FLAG]  = riseVec[`SMR_B_THERMAL_SHUTDOWN_FLAG];
        eventVec[`SMR_B_FAULT]   = riseVec[`SMR_B_FAULT];
        eventVec[`SMR_B_UVLO]    = riseVec[`SMR_B_UVLO];
        eventVec[`SMR_B_OVERTEMP_WARNING]   = riseVec[`SMR_B_OVERTEMP_WARNING];
        eventVec[`SMR_B_SUPWARN] = riseVec[`SMR_B_SUPWARN]
                                   & st_q.mode.supplyWarningIrqOn; // RL14
        eventVec[`SMR_B_WAKE]    = syncIn[`SMR_I_WAKE] & ~st_q.wakePrev
                                   & ~st_q.mode.wakeupDetectOff; // RL11 RL20
    end

    // Reading the latched flags clears them
    assign irqRead = regRead & addrHit(regAddr, `SMR_ADDR_IRQ); // RL19

    assign irqBus.events   = eventVec;
    assign irqBus.clearAll = irqRead;
    assign irqBus.suppress = st_q.mode.rst; // RL10

    smr_irq uIrq (
        .clock (clock),
        .rstn  (rstn),
        .irq   (irqBus)
    );

    // Next state of the bank
    always_comb begin
        st_d        = st_q;
        st_d.rvalid = 1'b0;

        // Live flags follow the synchronised conditions
        st_d.status.thermalShutdownFlag = syncIn[`SMR_I_THERMAL_SHUTDOWN_FLAG]; // RL1
        st_d.status.auxInputLevel       = syncIn[`SMR_I_AUX]; // RL2
        st_d.status.unused5             = 1'b0; // RL8
        st_d.status.lineDriverFaultBit  = syncIn[`SMR_I_FAULT]; // RL3
        st_d.status.supplyLowWarning    = syncIn[`SMR_I_SUPWARN]; // RL4
        st_d.status.supplyUndervoltage  = syncIn[`SMR_I_UVLO]; // RL5
        st_d.status.lineLevel           = syncIn[`SMR_I_LINE]; // RL6

        // Warning sets above the threshold and only clears below the lower one
        if (syncIn[`SMR_I_TEMPHI]) begin
            st_d.status.overtempWarning = 1'b1; // RL7
        end else if (syncIn[`SMR_I_TEMPLO]) begin
            st_d.status.overtempWarning = 1'b0; // RL7
        end

        // Register reset holds the status cleared
        if (st_q.mode.rst) begin
            st_d.status = `SMR_STATUS_RST; // RL9
        end
        st_d.statusPrev = st_q.status;
        st_d.wakePrev   = syncIn[`SMR_I_WAKE];

        // Mode write; the reset bit wipes every other field while it is held
        if (regWrite && addrHit(regAddr, `SMR_ADDR_MODE)) begin
            if (regWdata[`SMR_M_RST]) begin
                st_d.mode     = `SMR_MODE_RST; // RL9
                st_d.mode.rst = 1'b1;
            end else begin
                st_d.mode = regWdata; // RL18
            end
        end else if (st_q.mode.rst) begin
            st_d.mode     = `SMR_MODE_RST;
            st_d.mode.rst = 1'b1;
        end

        // Reads return registered data one cycle later and change nothing here
        if (regRead) begin
            st_d.rdata  = readMux(regAddr, st_q.status, st_q.mode, irqBus.flags); // RL8 RL18
            st_d.rvalid = 1'b1;
        end

        // Indicator 1 is forced high or follows its input pin
        st_d.indicator1Out = st_q.mode.indicator1Force | syncIn[`SMR_I_IND1]; // RL17
    end

    // State register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q.mode          <= `SMR_MODE_RST;
            st_q.status        <= `SMR_STATUS_RST;
            st_q.statusPrev    <= `SMR_STATUS_RST;
            st_q.wakePrev      <= 1'b0;
            st_q.rdata         <= 8'h00;
            st_q.rvalid        <= 1'b0;
            st_q.indicator1Out <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the flip-flops
    assign regRdata        = st_q.rdata;
    assign regRvalid       = st_q.rvalid;
    assign wakeupDetectOff = st_q.mode.wakeupDetectOff; // RL11
    assign regulator3v3Off = st_q.mode.regulator3v3Off; // RL12
    assign serialMuxOn     = st_q.mode.serialMuxOn; // RL13
    assign rxFilterBypass  = st_q.mode.rxFilterBypass; // RL15
    assign indicator2Level = st_q.mode.indicator2Level; // RL16
    assign indicator1Out   = st_q.indicator1Out;
    assign faultIrqN       = irqBus.irqN; // RL19
endmodule // status_mode_registers

`default_nettype wire

// ==== verification/smr_chk.sv ====
// Port-level assertions for the status and mode register bank
`timescale 1ns/1ns
`default_nettype none

module smr_chk (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic [2:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic       regRvalid,
    input wire logic       wakeupDetectOff,
    input wire logic       regulator3v3Off,
    input wire logic       serialMuxOn,
    input wire logic       rxFilterBypass,
    input wire logic       indicator2Level,
    input wire logic       indicator1Out,
    input wire logic       faultIrqN
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [7:0] modeQ;
    logic [4:0] ctl;
    logic [4:0] wctl;
    logic       softD;
    assign ctl  = {wakeupDetectOff, regulator3v3Off, serialMuxOn, rxFilterBypass, indicator2Level};
    assign wctl = {regWdata[6:4], regWdata[2:1]};
    // Shadow of the mode register; a set reset bit stores 0x80 only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            modeQ <= 8'h00;
            softD <= 1'b0;
        end else begin
            if (regWrite && regAddr == 3'h2) modeQ <= regWdata[7] ? 8'h80 : regWdata;
            softD <= modeQ[7];
        end
    end
    sequence modeWr;
        regWrite && regAddr == 3'h2;
    endsequence
    read_answer_a: assert property (regRead |=> regRvalid) else $error("read not answered");
    answer_idle_a: assert property (!regRead |=> !regRvalid) else $error("stray read answer");
    rdata_hold_a: assert property (!regRead |=> $stable(regRdata)) else $error("read data moved");
    unmapped_zero_a: assert property (regRead && regAddr > 3'h2 |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    status_bit5_a: assert property (regRead && regAddr == 3'h0 |=> !regRdata[5])
        else $error("unused status bit set");
    mode_read_a: assert property (regRead && regAddr == 3'h2 |=> regRdata == $past(modeQ))
        else $error("mode readback wrong");
    mode_outputs_a: assert property (modeWr ##0 !regWdata[7] |=> ctl == $past(wctl))
        else $error("mode outputs wrong");
    soft_quiet_a: assert property (softD && modeQ[7] |-> ctl == 5'h00 && faultIrqN)
        else $error("soft reset not quiet");
    ind1_force_a: assert property (modeWr ##0 regWdata[0] && !regWdata[7] |=> ##1 indicator1Out)
        else $error("indicator 1 not forced");
endmodule // smr_chk

bind status_mode_registers smr_chk u_smr_chk (.clock, .rstn, .regAddr, .regWrite, .regRead,
    .regWdata, .regRdata, .regRvalid, .wakeupDetectOff, .regulator3v3Off, .serialMuxOn,
    .rxFilterBypass, .indicator2Level, .indicator1Out, .faultIrqN);

`default_nettype wire

// ==== verification/smr_host.sv ====
// Host model driving the register port of the bank
`timescale 1ns/1ns
`default_nettype none

module smr_host (
    input  wire logic       clock,
    output logic      [2:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWdata,
    input  wire logic [7:0] regRdata,
    input  wire logic       regRvalid
);
    // Idle port at time zero
    initial begin
        regAddr = 3'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
    end
    // Strobe spans one edge; data flipped afterwards so no stale value lingers
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge clock);
        #1;
        regWrite = 1'b0;
        regWdata = ~d;
    endtask
    // Answer awaited under a small bound
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge clock);
        #1;
        regRead = 1'b0;
        for (int i = 0; i < 4 && regRvalid !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        d = regRdata;
    endtask
endmodule // smr_host

`default_nettype wire

// ==== verification/status_mode_registers_tb.sv ====
// Self-checking testbench of the status and mode register bank
`timescale 1ns/1ns
`default_nettype none

module status_mode_registers_tb;
    logic       clock, rstn, regWrite, regRead, regRvalid;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata, ctl;
    logic       thermalShutdown, auxDigitalInput, lineDriverFault, supplyLowWarning;
    logic       supplyUndervoltage, linePinLevel, tempAboveWarn, tempBelowHyst;
    logic       wakeupDetect, indicator1Input, indicator1Out, faultIrqN;
    logic       wakeupDetectOff, regulator3v3Off, serialMuxOn, rxFilterBypass, indicator2Level;
    int         errTotal, nChecks;
    assign ctl = {3'h0, wakeupDetectOff, regulator3v3Off, serialMuxOn, rxFilterBypass,
                  indicator2Level};

    status_mode_registers u_status_mode_registers (.clock, .rstn, .regAddr, .regWrite,
        .regRead, .regWdata, .regRdata, .regRvalid, .thermalShutdown, .auxDigitalInput,
        .lineDriverFault, .supplyLowWarning, .supplyUndervoltage, .linePinLevel,
        .tempAboveWarn, .tempBelowHyst, .wakeupDetect, .indicator1Input, .wakeupDetectOff,
        .regulator3v3Off, .serialMuxOn, .rxFilterBypass, .indicator2Level, .indicator1Out,
        .faultIrqN);
    smr_host u_smr_host (.clock, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
        .regRvalid);

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic exp, input logic got);
        chk(nm, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_smr_host.rd(a, d);
        chk($sformatf("register %0h", a), exp, d);
    endtask
    // Long enough for synchroniser, status and interrupt flag to land
    task automatic settle;
        repeat (6) @(posedge clock);
        #1;
    endtask
    // Drives the condition inputs so the status should read s
    task automatic setc(input logic [7:0] s);
        thermalShutdown = s[7];
        auxDigitalInput = ~s[6];
        lineDriverFault = s[4];
        supplyLowWarning = s[3];
        supplyUndervoltage = s[2];
        linePinLevel = ~s[1];
        settle;
    endtask
    task automatic endOfTest;
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        errTotal++;
        $display("ERROR watchdog expected finish seen hang");
        endOfTest;
    end
    initial begin
        logic [7:0] d, e;
        errTotal = 0;
        nChecks = 0;
        rstn = 1'b0;
        {tempAboveWarn, tempBelowHyst, wakeupDetect, indicator1Input} = 4'h4;
        {thermalShutdown, lineDriverFault, supplyLowWarning, supplyUndervoltage} = 4'h0;
        {auxDigitalInput, linePinLevel} = 2'h3;
        repeat (12) @(posedge clock);
        #1;
        rstn = 1'b1;
        rdc(3'h0, 8'h00);
        rdc(3'h2, 8'h00);
        chk1("irqN", 1'b1, faultIrqN);
        u_smr_host.wr(3'h0, 8'hFF);
        rdc(3'h0, 8'h00);
        $display("test reset done");
        for (int i = 1; i < 8; i++) begin
            if (i == 5) continue;
            d = 8'h01 << i;
            e = d & 8'h94;
            setc(d);
            chk1("irqN", e == 8'h00, faultIrqN);
            rdc(3'h1, e);
            chk1("irqN", 1'b1, faultIrqN);
            rdc(3'h0, d);
            rdc(3'h0, d);
        end
        setc(8'h00);
        {tempAboveWarn, tempBelowHyst} = 2'h2;
        settle;
        rdc(3'h0, 8'h01);
        tempAboveWarn = 1'b0;
        settle;
        rdc(3'h0, 8'h01);
        tempBelowHyst = 1'b1;
        settle;
        rdc(3'h0, 8'h00);
        rdc(3'h1, 8'h01);
        $display("test status done");
        u_smr_host.wr(3'h2, 8'h2A);
        chk("ctl", 8'h09, ctl);
        rdc(3'h2, 8'h2A);
        setc(8'h08);
        rdc(3'h1, 8'h08);
        wakeupDetect = 1'b1;
        settle;
        wakeupDetect = 1'b0;
        rdc(3'h1, 8'h40);
        chk1("ind1", 1'b0, indicator1Out);
        indicator1Input = 1'b1;
        settle;
        chk1("ind1", 1'b1, indicator1Out);
        indicator1Input = 1'b0;
        u_smr_host.wr(3'h2, 8'h55);
        chk("ctl", 8'h16, ctl);
        settle;
        chk1("ind1", 1'b1, indicator1Out);
        setc(8'h00);
        wakeupDetect = 1'b1;
        settle;
        wakeupDetect = 1'b0;
        setc(8'h08);
        rdc(3'h1, 8'h00);
        $display("test mode done");
        setc(8'h80);
        chk1("irqN", 1'b0, faultIrqN);
        u_smr_host.wr(3'h2, 8'h80);
        settle;
        chk1("irqN", 1'b1, faultIrqN);
        chk("ctl", 8'h00, ctl);
        rdc(3'h0, 8'h00);
        rdc(3'h2, 8'h80);
        setc(8'h00);
        setc(8'h94);
        chk1("irqN", 1'b1, faultIrqN);
        rdc(3'h1, 8'h00);
        setc(8'h00);
        u_smr_host.wr(3'h2, 8'h00);
        rdc(3'h2, 8'h00);
        rdc(3'h7, 8'h00);
        $display("test soft reset done");
        endOfTest;
    end
endmodule // status_mode_registers_tb

`default_nettype wire
